//--- core/lockup_supervisor.sv
// lockup supervisor: two-stage lockup timer, boot fetch watch, ecc routing, function disable, intrusion
`timescale 1ns/1ps
`include "lockup_supervisor_cfg.svh"
module lockup_supervisor #(
	parameter int unsigned FETCH_WAIT_CYC = `FETCH_WAIT_NS / `CLK_PERIOD_NS,
	parameter int unsigned RST_PULSE_CYC = `RST_PULSE_NS / `CLK_PERIOD_NS
) (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// pins from outside the clock domain
	input wire logic intruder_n,
	input wire logic cpu_fetch,
	// memory controller and integrated functions
	input wire lockup_supervisor_pkg::ecc_msg_t ecc_msg,
	input wire lockup_supervisor_pkg::func_req_t func_req,
	output lockup_supervisor_pkg::func_req_t func_gated,
	// system outputs
	output logic mgmt_interrupt_n,
	output logic nmi,
	output logic system_error_n,
	output logic lockup_irq,
	output logic sys_reset_n,
	output logic irq
);
	localparam int unsigned SW = `ST_WIDTH;
	logic [31:0] ctrl_reg;
	logic [31:0] reload_reg;
	logic [31:0] count_reg;
	logic [SW-1:0] status_reg;
	logic [SW-1:0] mask_reg;
	logic [`FDIS_WIDTH-1:0] fdis_reg;
	logic first_exp_reg;
	logic [31:0] rst_cnt_reg;
	logic [31:0] boot_cnt_reg;
	lockup_supervisor_pkg::boot_state_t boot_reg;
	logic [1:0] intr_sync_reg;
	logic [1:0] fetch_sync_reg;
	logic wr_pend_reg;
	logic [7:0] wr_addr_reg;
	logic wr_en;
	logic kick;
	logic tmr_zero;
	logic boot_miss;
	logic fire_reset;
	logic [SW-1:0] st_set;
	logic [SW-1:0] st_clr;
	logic [31:0] rd_next;
	logic intr_active;
	logic fetch_seen;

	// pins pass two flops before use
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			intr_sync_reg <= 2'h3;
			fetch_sync_reg <= 2'h0;
		end
		else
		begin
			intr_sync_reg <= {intr_sync_reg[0], intruder_n};
			fetch_sync_reg <= {fetch_sync_reg[0], cpu_fetch};
		end
	end
	assign intr_active = !intr_sync_reg[1];
	assign fetch_seen = fetch_sync_reg[1];

	// bus: never waits, always okay; write lands in the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend_reg <= hsel && htrans[1] && hwrite && hready;
			wr_addr_reg <= haddr;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
	assign wr_en = wr_pend_reg;
	assign kick = wr_en && (wr_addr_reg == `OFS_KICK);

	// read data chosen in the address phase so hrdata stands from a flop
	always_comb
	begin
		rd_next = 32'h0;
		if (haddr == `OFS_CTRL)
			rd_next = ctrl_reg;
		else if (haddr == `OFS_RELOAD)
			rd_next = reload_reg;
		else if (haddr == `OFS_COUNT)
			rd_next = count_reg;
		else if (haddr == `OFS_STATUS)
			rd_next = {{(32-SW){1'b0}}, status_reg};
		else if (haddr == `OFS_MASK)
			rd_next = {{(32-SW){1'b0}}, mask_reg};
		else if (haddr == `OFS_FDIS)
			rd_next = {{(32-`FDIS_WIDTH){1'b0}}, fdis_reg};
		else
			rd_next = 32'h0;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h0;
		else if (hsel && htrans[1] && !hwrite && hready)
			hrdata <= rd_next;
	end

	// software-written configuration
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg <= `CTRL_RESET;
			reload_reg <= `RELOAD_RESET;
			mask_reg <= '0;
			fdis_reg <= '0;
		end
		else if (wr_en)
		begin
			if (wr_addr_reg == `OFS_CTRL)
				ctrl_reg <= hwdata & `CTRL_WR_MASK;
			else if (wr_addr_reg == `OFS_RELOAD)
				reload_reg <= hwdata;
			else if (wr_addr_reg == `OFS_MASK)
				mask_reg <= hwdata[SW-1:0];
			else if (wr_addr_reg == `OFS_FDIS)
				fdis_reg <= hwdata[`FDIS_WIDTH-1:0];
		end
	end

	// lockup timer; reload value zero still takes one cycle per stage
	assign tmr_zero = ctrl_reg[`CTRL_TMR_EN] && (count_reg == 32'h0);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			count_reg <= `RELOAD_RESET;
			first_exp_reg <= 1'b0;
		end
		else if (kick || !ctrl_reg[`CTRL_TMR_EN])
		begin
			count_reg <= reload_reg;
			first_exp_reg <= 1'b0;
		end
		else if (tmr_zero)
		begin
			count_reg <= reload_reg;
			first_exp_reg <= !first_exp_reg;
		end
		else
			count_reg <= count_reg - 32'h1;
	end

	// boot fetch watch, restarted after each reboot it causes
	assign boot_miss = (boot_reg == lockup_supervisor_pkg::BOOT_WAIT) && !fetch_seen
		&& ctrl_reg[`CTRL_FETCH_CHK_EN] && (boot_cnt_reg == FETCH_WAIT_CYC - 1);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			boot_reg <= lockup_supervisor_pkg::BOOT_WAIT;
			boot_cnt_reg <= 32'h0;
		end
		else
		begin
			case (boot_reg)
				lockup_supervisor_pkg::BOOT_WAIT:
				begin
					if (fetch_seen)
						boot_reg <= lockup_supervisor_pkg::BOOT_DONE;
					else if (boot_miss || rst_cnt_reg != 32'h0)
						boot_cnt_reg <= 32'h0;
					else if (boot_cnt_reg < FETCH_WAIT_CYC - 1)
						boot_cnt_reg <= boot_cnt_reg + 32'h1; // saturates while the check is off, no wrap
				end
				lockup_supervisor_pkg::BOOT_DONE:
					boot_reg <= lockup_supervisor_pkg::BOOT_DONE;
				default:
					boot_reg <= lockup_supervisor_pkg::BOOT_WAIT;
			endcase
		end
	end

	// system reset pulse from second run-out or missing fetch
	assign fire_reset = (tmr_zero && first_exp_reg && !kick) || boot_miss;
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rst_cnt_reg <= 32'h0;
			sys_reset_n <= 1'b1;
		end
		else if (fire_reset && rst_cnt_reg == 32'h0)
		begin
			rst_cnt_reg <= RST_PULSE_CYC;
			sys_reset_n <= 1'b0;
		end
		else if (rst_cnt_reg != 32'h0)
		begin
			rst_cnt_reg <= rst_cnt_reg - 32'h1;
			sys_reset_n <= (rst_cnt_reg == 32'h1);
		end
	end

	// sticky events; a set in the clearing cycle wins
	always_comb
	begin
		st_set = '0;
		st_set[`ST_FIRST_EXP] = tmr_zero && !first_exp_reg && !kick;
		st_set[`ST_ECC_MGMT] = ecc_msg.valid && ecc_msg.sel == lockup_supervisor_pkg::ECC_MGMT;
		st_set[`ST_ECC_NMI] = ecc_msg.valid && ecc_msg.sel == lockup_supervisor_pkg::ECC_NMI;
		st_set[`ST_ECC_SYS_ERR] = ecc_msg.valid && ecc_msg.sel == lockup_supervisor_pkg::ECC_SYS_ERR;
		st_set[`ST_ECC_LOCKUP] = ecc_msg.valid && ecc_msg.sel == lockup_supervisor_pkg::ECC_LOCKUP;
		st_set[`ST_INTR_MGMT] = intr_active && !ctrl_reg[`CTRL_INTR_TO_LOCKUP];
		st_set[`ST_INTR_LOCKUP] = intr_active && ctrl_reg[`CTRL_INTR_TO_LOCKUP];
		st_set[`ST_FETCH_MISS] = boot_miss;
		st_clr = (wr_en && wr_addr_reg == `OFS_STATUS) ? hwdata[SW-1:0] : '0;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			status_reg <= '0;
		else
			status_reg <= (status_reg & ~st_clr) | st_set;
	end

	// interrupt pins follow the status bits that feed them
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mgmt_interrupt_n <= 1'b1;
			nmi <= 1'b0;
			system_error_n <= 1'b1;
			lockup_irq <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			mgmt_interrupt_n <= !(status_reg[`ST_FIRST_EXP] || status_reg[`ST_ECC_MGMT]
				|| status_reg[`ST_INTR_MGMT]);
			nmi <= status_reg[`ST_ECC_NMI];
			system_error_n <= !status_reg[`ST_ECC_SYS_ERR];
			lockup_irq <= status_reg[`ST_ECC_LOCKUP] || status_reg[`ST_INTR_LOCKUP];
			irq <= |(status_reg & mask_reg);
		end
	end

	// function gating
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			func_gated <= '0;
		else
		begin
			func_gated.decode <= func_req.decode & ~fdis_reg;
			func_gated.irq <= func_req.irq & ~fdis_reg;
			func_gated.pme <= func_req.pme & ~fdis_reg;
		end
	end

	// checks
	first_exp_mgmt_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_set[`ST_FIRST_EXP] |-> ##2 !mgmt_interrupt_n)
		else $error("first run-out did not raise the management interrupt");
	second_exp_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tmr_zero && first_exp_reg && !kick && rst_cnt_reg == 32'h0) |=> !sys_reset_n)
		else $error("second run-out did not reset the system");
	boot_miss_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(boot_miss && rst_cnt_reg == 32'h0) |=> !sys_reset_n && status_reg[`ST_FETCH_MISS])
		else $error("missing fetch did not reboot");
	ecc_nmi_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ecc_msg.valid && ecc_msg.sel == lockup_supervisor_pkg::ECC_NMI) |-> ##2 nmi)
		else $error("ecc message did not raise nmi");
	ecc_sys_err_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(ecc_msg.valid && ecc_msg.sel == lockup_supervisor_pkg::ECC_SYS_ERR) |-> ##2 !system_error_n)
		else $error("ecc message did not raise system error");
	fdis_decode_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(fdis_reg == $past(fdis_reg)) |=> ((func_gated.decode & $past(fdis_reg)) == 6'h0))
		else $error("disabled function still decodes");
	fdis_irq_pme_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(fdis_reg == $past(fdis_reg)) |=> (((func_gated.irq | func_gated.pme) & $past(fdis_reg)) == 6'h0))
		else $error("disabled function raised an event");
	intrusion_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(intr_active && ctrl_reg[`CTRL_INTR_TO_LOCKUP]) |-> ##2 lockup_irq)
		else $error("intrusion did not raise lockup interrupt");
	kick_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
		kick |=> (count_reg == $past(reload_reg)) && !first_exp_reg)
		else $error("reload did not restart the timer");
	first_exp_c: cover property (@(posedge hclk) disable iff (!hresetn) st_set[`ST_FIRST_EXP]);
	system_reset_c: cover property (@(posedge hclk) disable iff (!hresetn) $fell(sys_reset_n));
	fetch_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
		boot_reg == lockup_supervisor_pkg::BOOT_DONE);
	intrusion_c: cover property (@(posedge hclk) disable iff (!hresetn) st_set[`ST_INTR_MGMT]);
endmodule

//--- core/lockup_supervisor_cfg.svh
// address map, field positions, reset values and timing figures of the lockup supervisor
`ifndef LOCKUP_SUPERVISOR_CFG_SVH
`define LOCKUP_SUPERVISOR_CFG_SVH
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_RELOAD 8'h04
`define OFS_KICK 8'h08
`define OFS_COUNT 8'h0c
`define OFS_STATUS 8'h10
`define OFS_MASK 8'h14
`define OFS_FDIS 8'h18
// control fields
`define CTRL_TMR_EN 0
`define CTRL_INTR_TO_LOCKUP 1
`define CTRL_FETCH_CHK_EN 2
`define CTRL_RESET 32'h0000_0004
`define CTRL_WR_MASK 32'h0000_0007
// status / mask fields
`define ST_FIRST_EXP 0
`define ST_ECC_MGMT 1
`define ST_ECC_NMI 2
`define ST_ECC_SYS_ERR 3
`define ST_ECC_LOCKUP 4
`define ST_INTR_MGMT 5
`define ST_INTR_LOCKUP 6
`define ST_FETCH_MISS 7
`define ST_WIDTH 8
`define FDIS_WIDTH 6
`define RELOAD_RESET 32'h0000_ffff
// timing
`define CLK_PERIOD_NS 40
`define FETCH_WAIT_NS 1000000
`define RST_PULSE_NS 1000
`endif

//--- core/lockup_supervisor_pkg.sv
// types shared by the lockup supervisor and its bench
package lockup_supervisor_pkg;
	// ecc message from the memory host controller
	typedef enum logic [1:0] {
		ECC_MGMT = 2'h0,
		ECC_NMI = 2'h1,
		ECC_SYS_ERR = 2'h2,
		ECC_LOCKUP = 2'h3
	} ecc_sel_t;
	typedef struct packed {
		logic valid;
		ecc_sel_t sel;
	} ecc_msg_t;
	// boot fetch watch
	typedef enum logic [1:0] {
		BOOT_WAIT = 2'b01,
		BOOT_DONE = 2'b10
	} boot_state_t;
	// per-function request lines: lan, usb, lpc, sata, pcie, smbus
	typedef struct packed {
		logic [5:0] decode;
		logic [5:0] irq;
		logic [5:0] pme;
	} func_req_t;
endpackage

//--- tb/host_partner.sv
// far-side model: processor fetch pin, memory controller ecc messages, case switch
`timescale 1ns/1ps
module host_partner (
	// clock
	input wire logic hclk,
	// pins toward the supervisor
	output logic cpu_fetch,
	output logic intruder_n,
	output lockup_supervisor_pkg::ecc_msg_t ecc_msg
);
	// quiet pins until a scenario asks
	initial
	begin
		cpu_fetch = 1'b0;
		intruder_n = 1'b1;
		ecc_msg = '0;
	end
	// one message per detected error, a single cycle long
	task automatic send_ecc(input lockup_supervisor_pkg::ecc_sel_t s);
		@(posedge hclk);
		ecc_msg <= '{valid: 1'b1, sel: s};
		@(posedge hclk);
		ecc_msg <= '{valid: 1'b0, sel: lockup_supervisor_pkg::ecc_sel_t'(~s)}; // idle select is junk, never the last value
	endtask
	// processor fetch and intrusion switch levels
	task automatic set_pins(input logic f, input logic in_n);
		@(posedge hclk);
		cpu_fetch <= f;
		intruder_n <= in_n;
	endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the lockup supervisor
`timescale 1ns/1ps
module testbench;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready, hresp, cpu_fetch, intruder_n, mgmt_interrupt_n, nmi, system_error_n, lockup_irq, sys_reset_n, irq;
	logic [31:0] hrdata, rd;
	logic [5:0] fd;
	lockup_supervisor_pkg::ecc_msg_t ecc_msg;
	lockup_supervisor_pkg::func_req_t func_req = '0;
	lockup_supervisor_pkg::func_req_t func_gated;
	int bad_count = 0;
	int comparisons = 0;
	int seed = 58;
	int n;
	always #20 hclk = ~hclk;
	// short fetch wait and reset pulse keep the run brief
	lockup_supervisor #(.FETCH_WAIT_CYC(50), .RST_PULSE_CYC(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .intruder_n(intruder_n), .cpu_fetch(cpu_fetch),
		.ecc_msg(ecc_msg), .func_req(func_req), .func_gated(func_gated), .mgmt_interrupt_n(mgmt_interrupt_n),
		.nmi(nmi), .system_error_n(system_error_n), .lockup_irq(lockup_irq), .sys_reset_n(sys_reset_n), .irq(irq));
	host_partner host (.hclk(hclk), .cpu_fetch(cpu_fetch), .intruder_n(intruder_n), .ecc_msg(ecc_msg));
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] want);
		comparisons++;
		if (got !== want)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// single word transfer; waits on hready, read data taken at the data-phase edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1 && ++k < 100);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1 && ++k < 100);
		r = hrdata;
		check(hresp, 32'h0);
		check(32'(k < 100), 32'h1); // a wait that runs out counts as a mismatch
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
		bus(1'b0, a, 32'h0, rd);
		check(rd, want);
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge hclk);
	endtask
	// watchdog sized well beyond the few hundred cycles the tests need
	initial
	begin
		#(40 * 20000);
		bad_count++;
		end_of_test();
	end
	initial
	begin
		cyc(20);
		hresetn <= 1'b1;
		// no fetch after reset: reboot pulse
		n = 0;
		while (sys_reset_n !== 1'b0 && n < 200)
		begin
			@(posedge hclk);
			n++;
		end
		check(32'(n >= 48 && n < 60), 32'h1);
		n = 0;
		while (sys_reset_n === 1'b0 && n < 50)
		begin
			@(posedge hclk);
			n++;
		end
		check(n, 32'd4);
		host.set_pins(1'b1, 1'b1);
		rdchk(8'h00, 32'h4);
		rdchk(8'h04, 32'hffff);
		rdchk(8'h10, 32'h80);
		rdchk(8'h40, 32'h0);
		wr(8'h10, 32'h80);
		rdchk(8'h10, 32'h0);
		cyc(80);
		check(sys_reset_n, 32'h1);
		// two-stage timer
		wr(8'h04, 32'h14);
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h1);
		n = 0;
		while (mgmt_interrupt_n !== 1'b0 && n < 60)
		begin
			@(posedge hclk);
			n++;
		end
		check(sys_reset_n, 32'h1);
		rdchk(8'h10, 32'h1);
		wr(8'h08, 32'h0);
		wr(8'h10, 32'h1);
		n = 0;
		while (sys_reset_n !== 1'b0 && n < 100)
		begin
			@(posedge hclk);
			n++;
		end
		check(32'(n > 25 && n < 50), 32'h1);
		wr(8'h00, 32'h0);
		rdchk(8'h0c, 32'h14);
		wr(8'h10, 32'hff);
		rdchk(8'h10, 32'h0);
		// every ecc message kind
		for (int s = 0; s < 4; s++)
		begin
			host.send_ecc(lockup_supervisor_pkg::ecc_sel_t'(s));
			cyc(3);
			check({~mgmt_interrupt_n, nmi, ~system_error_n, lockup_irq}, 32'h8 >> s);
			rdchk(8'h10, 32'h2 << s);
			wr(8'h10, 32'hff);
		end
		// intrusion routed by control bit 1
		for (int b = 0; b < 2; b++)
		begin
			wr(8'h00, 32'(b) << 1);
			host.set_pins(1'b1, 1'b0);
			cyc(6);
			check({~mgmt_interrupt_n, lockup_irq}, b ? 32'h1 : 32'h2);
			rdchk(8'h10, 32'h20 << b);
			host.set_pins(1'b1, 1'b1);
			cyc(4);
			wr(8'h10, 32'hff);
			rdchk(8'h10, 32'h0);
		end
		// interrupt raise, mask, clear
		wr(8'h14, 32'h2);
		host.send_ecc(lockup_supervisor_pkg::ECC_MGMT);
		cyc(4);
		check(irq, 32'h1);
		wr(8'h14, 32'h0);
		cyc(2);
		check(irq, 32'h0);
		wr(8'h14, 32'h2);
		cyc(2);
		check(irq, 32'h1);
		wr(8'h10, 32'h2);
		cyc(2);
		check(irq, 32'h0);
		// random disables against random requests
		for (int i = 0; i < 8; i++)
		begin
			fd = 6'($random(seed));
			wr(8'h18, 32'(fd));
			rdchk(8'h18, 32'(fd));
			@(posedge hclk);
			func_req <= 18'($random(seed));
			cyc(3);
			check(32'(func_gated), 32'(func_req & ~{fd, fd, fd}));
		end
		end_of_test();
	end
endmodule
